/* rtl/fml_margin_ctl.sv */
// Margin level command controller with its register port.
//
// Contract
// - Code 0x0d selects the user command; words 0 and 1 hold the address.
// - User launch stores the level on the same edge as the complete flag sets again.
// - A user level aimed at the EEPROM changes only the EEPROM level.
// - A user level aimed at program flash sets both read levels.
// - User settings 0, 1, 2 are normal, erased margin, programmed margin.
// - Either command sets the access error if the index is not 2 at launch.
// - Either command sets the access error for a setting outside its set.
// - Either command sets the access error for a bad address; only the field command for a bad mode.
// - Code 0x0e selects the field command, allowed only in special mode.
// - Field launch stores the level on the same edge as the complete flag sets again.
// - A field level aimed at the EEPROM changes only the EEPROM level.
// - A field level aimed at program flash sets both read levels.
// - Field settings add 3 and 4: field margin toward erased, programmed.
`timescale 1ns/1ps
module fml_margin_ctl #(
    parameter logic [23:0] PF_LO = fml_pkg::PF_LO_DEF,
    parameter logic [23:0] PF_HI = fml_pkg::PF_HI_DEF,
    parameter logic [23:0] EE_LO = fml_pkg::EE_LO_DEF,
    parameter logic [23:0] EE_HI = fml_pkg::EE_HI_DEF
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [15:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [15:0] bus_rdata,
    input  wire logic        special_mode_pin,
    output logic             irq,
    output logic      [2:0]  pflash_margin,
    output logic      [2:0]  eeprom_margin,
    output logic             busy
);

    // ****************************************************************
    // Register decode
    // ****************************************************************
    // The status, index, word and enable selects are shared by the write decode and the read port.
    wire sel_status = (bus_addr == fml_pkg::REG_STATUS);
    wire sel_index  = (bus_addr == fml_pkg::REG_INDEX);
    wire sel_word   = (bus_addr == fml_pkg::REG_WORD);
    wire sel_margin = (bus_addr == fml_pkg::REG_MARGIN);
    wire sel_istat  = (bus_addr == fml_pkg::REG_IRQ_STAT);
    wire sel_iclr   = (bus_addr == fml_pkg::REG_IRQ_CLR);
    wire sel_ien    = (bus_addr == fml_pkg::REG_IRQ_EN);

    wire wr_status = bus_wr && sel_status;
    wire wr_index  = bus_wr && sel_index;
    wire wr_word   = bus_wr && sel_word;
    wire wr_clr    = bus_wr && sel_iclr;
    wire wr_en     = bus_wr && sel_ien;

    fml_pkg::fml_state_t state;
    fml_pkg::fml_state_t next_state;
    fml_pkg::fml_cmd_t   cmd;

    logic                       command_complete_flag;
    logic                       access_error_flag;
    logic [fml_pkg::IDX_W-1:0]  index;
    logic [fml_pkg::IDX_W-1:0]  next_index;
    logic [fml_pkg::IDX_W-1:0]  ram_raddr;
    logic [15:0]                ram_rdata;
    logic [15:0]                word0;
    logic [15:0]                word1;
    logic                       bad_index;
    logic                       mode_meta;
    logic                       mode_sync;
    logic [fml_pkg::EVT_W-1:0]  irq_status;
    logic [fml_pkg::EVT_W-1:0]  irq_enable;
    logic [fml_pkg::EVT_W-1:0]  events;
    logic [15:0]                read_mux;

    wire idle   = (state == fml_pkg::ST_IDLE);
    wire exec   = (state == fml_pkg::ST_EXEC);
    // Launch is a one written to the complete flag while it is set.
    wire launch = wr_status && bus_wdata[fml_pkg::BIT_COMMAND_COMPLETE_FLAG] && command_complete_flag;

    // ****************************************************************
    // Command word store
    // ****************************************************************
    // Software may not edit the words or the index while a command
    // runs; such writes are dropped rather than corrupt the fetch.
    assign next_index = (wr_index && idle)
                      ? bus_wdata[fml_pkg::IDX_W-1:0] : index;

    // Each fetch state reads one command word, in word order.
    assign ram_raddr = (state == fml_pkg::ST_W0) ? fml_pkg::WORD_CODE :
                       (state == fml_pkg::ST_W1) ? fml_pkg::WORD_ADDR :
                       (state == fml_pkg::ST_W2) ? fml_pkg::WORD_SET :
                                                   next_index;

    fml_word_ram #(
        .DEPTH (fml_pkg::WORDS),
        .AW    (fml_pkg::IDX_W),
        .DW    (fml_pkg::DATA_W)
    ) u_words (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .we      (wr_word && idle),
        .waddr   (index),
        .wdata   (bus_wdata),
        .raddr   (ram_raddr),
        .rdata   (ram_rdata)
    );

    // ****************************************************************
    // Command decode and checks
    // ****************************************************************
    assign cmd.code    = word0[15:8];
    assign cmd.gaddr   = {word0[7:0], word1};
    assign cmd.setting = ram_rdata;

    wire is_user  = (cmd.code == fml_pkg::CMD_USER);
    wire is_field = (cmd.code == fml_pkg::CMD_FIELD);
    wire in_pf    = fml_pkg::fml_in_range(cmd.gaddr, PF_LO, PF_HI);
    wire in_ee    = fml_pkg::fml_in_range(cmd.gaddr, EE_LO, EE_HI);
    wire addr_ok  = in_pf || in_ee;
    wire mode_ok  = is_user || (is_field && mode_sync);
    wire set_ok   = is_field
                  ? (cmd.setting <= fml_pkg::SET_FIELD_MAX)
                  : (cmd.setting <= fml_pkg::SET_USER_MAX);
    wire cmd_err  = bad_index || !mode_ok || !addr_ok || !set_ok;
    wire apply    = exec && !cmd_err;
    wire [2:0] lvl = cmd.setting[2:0];
    wire access_error_flag_set = exec && cmd_err;
    wire access_error_flag_clr = wr_status && bus_wdata[fml_pkg::BIT_ACCESS_ERROR_FLAG];
    // The windows do not overlap, so an applied target outside program
    // flash can only be the EEPROM.
    wire apply_pf   = apply && in_pf;
    wire apply_ee   = apply && !in_pf;
    wire busy_next  = (next_state != fml_pkg::ST_IDLE);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            fml_pkg::ST_IDLE: begin
                if (launch) begin
                    next_state = fml_pkg::ST_W0;
                end
            end
            fml_pkg::ST_W0: begin
                next_state = fml_pkg::ST_W1;
            end
            fml_pkg::ST_W1: begin
                next_state = fml_pkg::ST_W2;
            end
            fml_pkg::ST_W2: begin
                next_state = fml_pkg::ST_EXEC;
            end
            fml_pkg::ST_EXEC: begin
                next_state = fml_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state <= fml_pkg::ST_IDLE;
            index <= fml_pkg::INDEX_RST;
            word0 <= fml_pkg::DATA_ZERO;
            word1 <= fml_pkg::DATA_ZERO;
        end else begin
            state <= next_state;
            index <= next_index;
            if (state == fml_pkg::ST_W1) begin
                word0 <= ram_rdata;
            end
            if (state == fml_pkg::ST_W2) begin
                word1 <= ram_rdata;
            end
        end
    end

    // The index is judged as it stood at the launch write.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bad_index <= 1'b0;
        end else if (launch) begin
            bad_index <= (index != fml_pkg::INDEX_REQ);
        end
    end

    // ****************************************************************
    // Status flags
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            command_complete_flag <= 1'b1;
        end else if (exec) begin
            command_complete_flag <= 1'b1;
        end else if (launch) begin
            command_complete_flag <= 1'b0;
        end
    end

    // The error set in the last command cycle wins over a clear.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            access_error_flag <= 1'b0;
        end else if (access_error_flag_set) begin
            access_error_flag <= 1'b1;
        end else if (access_error_flag_clr) begin
            access_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            busy <= 1'b0;
        end else begin
            busy <= busy_next;
        end
    end

    // ****************************************************************
    // Read margin levels
    // ****************************************************************
    // Program flash targets drive both levels, since no setting may
    // leave EEPROM reads behind program flash reads.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pflash_margin <= fml_pkg::LVL_NORMAL;
            eeprom_margin <= fml_pkg::LVL_NORMAL;
        end else if (apply_pf) begin
            pflash_margin <= lvl;
            eeprom_margin <= lvl;
        end else if (apply_ee) begin
            eeprom_margin <= lvl;
        end
    end

    // ****************************************************************
    // Mode pin synchroniser
    // ****************************************************************
    // The pin is asynchronous, so a mode change reaches the field check
    // two cycles late; software must settle the mode before a launch.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mode_meta <= 1'b0;
            mode_sync <= 1'b0;
        end else begin
            mode_meta <= special_mode_pin;
            mode_sync <= mode_meta;
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    assign events[fml_pkg::EVT_DONE] = exec;
    assign events[fml_pkg::EVT_ERR]  = exec && cmd_err;

    fml_irq #(
        .N (fml_pkg::EVT_W)
    ) u_irq (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .event_in (events),
        .clr_wr   (wr_clr),
        .clr_data (bus_wdata[fml_pkg::EVT_W-1:0]),
        .en_wr    (wr_en),
        .en_data  (bus_wdata[fml_pkg::EVT_W-1:0]),
        .status   (irq_status),
        .enable   (irq_enable),
        .irq      (irq)
    );

    // ****************************************************************
    // Read port
    // ****************************************************************
    wire [15:0] status_word = 16'(({15'h0000, command_complete_flag} << fml_pkg::BIT_COMMAND_COMPLETE_FLAG)
                            | ({15'h0000, access_error_flag} << fml_pkg::BIT_ACCESS_ERROR_FLAG));
    wire [15:0] margin_word = 16'(({13'h0000, pflash_margin}
                                   << fml_pkg::MRG_PF_LSB)
                            | ({13'h0000, eeprom_margin}
                                   << fml_pkg::MRG_EE_LSB));

    assign read_mux =
        sel_status ? status_word :
        sel_index  ? {13'h0000, index} :
        sel_word   ? ram_rdata :
        sel_margin ? margin_word :
        sel_istat  ? {14'h0000, irq_status} :
        sel_ien    ? {14'h0000, irq_enable} :
                     fml_pkg::DATA_ZERO;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata <= fml_pkg::DATA_ZERO;
        end else if (bus_rd) begin
            bus_rdata <= read_mux;
        end else begin
            bus_rdata <= fml_pkg::DATA_ZERO;
        end
    end

endmodule

/* rtl/fml_pkg.sv */
// Constants, types and helper functions of the margin level command block.
package fml_pkg;

    // ****************************************************************
    // Register port geometry and register offsets
    // ****************************************************************
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 16;
    localparam int unsigned IDX_W    = 3;
    localparam int unsigned WORDS    = 6;
    localparam int unsigned GADDR_W  = 24;
    localparam int unsigned EVT_W    = 2;

    localparam logic [7:0] REG_STATUS   = 8'h00;
    localparam logic [7:0] REG_INDEX    = 8'h02;
    localparam logic [7:0] REG_WORD     = 8'h04;
    localparam logic [7:0] REG_MARGIN   = 8'h06;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_CLR  = 8'h0a;
    localparam logic [7:0] REG_IRQ_EN   = 8'h0c;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int unsigned BIT_COMMAND_COMPLETE_FLAG   = 7;
    localparam int unsigned BIT_ACCESS_ERROR_FLAG = 5;
    localparam int unsigned MRG_PF_LSB = 0;
    localparam int unsigned MRG_EE_LSB = 8;
    localparam int unsigned EVT_DONE   = 0;
    localparam int unsigned EVT_ERR    = 1;

    localparam logic [2:0]  INDEX_RST  = 3'h0;
    localparam logic [2:0]  INDEX_REQ  = 3'h2;
    localparam logic [2:0]  WORD_CODE  = 3'h0;
    localparam logic [2:0]  WORD_ADDR  = 3'h1;
    localparam logic [2:0]  WORD_SET   = 3'h2;
    localparam logic [15:0] DATA_ZERO  = 16'h0000;

    // ****************************************************************
    // Command codes and margin settings
    // ****************************************************************
    localparam logic [7:0]  CMD_USER       = 8'h0d;
    localparam logic [7:0]  CMD_FIELD      = 8'h0e;
    localparam logic [15:0] SET_USER_MAX   = 16'h0002;
    localparam logic [15:0] SET_FIELD_MAX  = 16'h0004;

    // Block address windows; plain defaults, override at the top.
    localparam logic [23:0] PF_LO_DEF = 24'h800000;
    localparam logic [23:0] PF_HI_DEF = 24'hffffff;
    localparam logic [23:0] EE_LO_DEF = 24'h100000;
    localparam logic [23:0] EE_HI_DEF = 24'h1007ff;

    typedef enum logic [2:0] {
        LVL_NORMAL = 3'h0,
        LVL_USER1  = 3'h1,
        LVL_USER0  = 3'h2,
        LVL_FIELD1 = 3'h3,
        LVL_FIELD0 = 3'h4
    } fml_level_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_W0   = 5'h02,
        ST_W1   = 5'h04,
        ST_W2   = 5'h08,
        ST_EXEC = 5'h10
    } fml_state_t;

    typedef struct packed {
        logic [7:0]  code;
        logic [23:0] gaddr;
        logic [15:0] setting;
    } fml_cmd_t;

    function automatic logic fml_in_range(
        input logic [23:0] a,
        input logic [23:0] lo,
        input logic [23:0] hi
    );
        fml_in_range = (a >= lo) && (a <= hi);
    endfunction

endpackage

/* rtl/fml_word_ram.sv */
// Small command word store with a registered, write-through read port.
`timescale 1ns/1ps
module fml_word_ram #(
    parameter int unsigned DEPTH = 6,
    parameter int unsigned AW    = 3,
    parameter int unsigned DW    = 16
) (
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [DEPTH];
    logic          hit;

    // Bypass keeps a write and a read of the same word in one cycle
    // coherent, so the next cycle already shows the new value.
    assign hit = we && (waddr == raddr);

    always_ff @(posedge clk_sys) begin
        if (we && (32'(waddr) < DEPTH)) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= '0;
        end else if (hit) begin
            rdata <= wdata;
        end else if (32'(raddr) < DEPTH) begin
            rdata <= mem[raddr];
        end else begin
            rdata <= '0;
        end
    end
endmodule

/* rtl/fml_irq.sv */
// Sticky event status, enable mask and level interrupt output.
`timescale 1ns/1ps
module fml_irq #(
    parameter int unsigned N = 2
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic [N-1:0] event_in,
    input  wire logic         clr_wr,
    input  wire logic [N-1:0] clr_data,
    input  wire logic         en_wr,
    input  wire logic [N-1:0] en_data,
    output logic      [N-1:0] status,
    output logic      [N-1:0] enable,
    output logic              irq
);
    logic [N-1:0] next_status;

    // A new event beats a clear in the same cycle.
    assign next_status = event_in | (status & ~(clr_data & {N{clr_wr}}));

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            status <= '0;
            enable <= '0;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            if (en_wr) begin
                enable <= en_data;
            end
            irq <= |(next_status & (en_wr ? en_data : enable));
        end
    end
endmodule

/* testbench/fml_margin_checker.sv */
// Port-level assertions for the margin level command controller.
`timescale 1ns/1ps
module fml_margin_checker (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic [7:0]  bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [15:0] bus_rdata,
    input wire logic        special_mode_pin,
    input wire logic        irq,
    input wire logic [2:0]  pflash_margin,
    input wire logic [2:0]  eeprom_margin,
    input wire logic        busy
);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    launch_busy_a: assert property (
        bus_wr && bus_addr == fml_pkg::REG_STATUS &&
        bus_wdata[fml_pkg::BIT_COMMAND_COMPLETE_FLAG] && !busy |=> busy [*4] ##1 !busy)
        else $error("launch did not run exactly four busy cycles");
    busy_cause_a: assert property (
        $rose(busy) |-> $past(bus_wr && bus_addr == fml_pkg::REG_STATUS &&
                              bus_wdata[fml_pkg::BIT_COMMAND_COMPLETE_FLAG]))
        else $error("busy rose without a launch write");
    pf_hold_a: assert property (
        !$stable(pflash_margin) |-> $fell(busy))
        else $error("flash level changed outside command completion");
    ee_hold_a: assert property (
        !$stable(eeprom_margin) |-> $fell(busy))
        else $error("eeprom level changed outside command completion");
    pf_both_a: assert property (
        !$stable(pflash_margin) |-> eeprom_margin == pflash_margin)
        else $error("flash level set without the eeprom level");
    level_range_a: assert property (
        pflash_margin <= 3'h4 && eeprom_margin <= 3'h4)
        else $error("read level outside the defined codes");
    margin_read_a: assert property (
        bus_rd && bus_addr == fml_pkg::REG_MARGIN |=> bus_rdata ==
        {5'h00, $past(eeprom_margin), 5'h00, $past(pflash_margin)})
        else $error("margin register read differs from level outputs");
    irq_cause_a: assert property (
        $rose(irq) |-> $fell(busy) ||
        $past(bus_wr && bus_addr == fml_pkg::REG_IRQ_EN) ||
        $past(bus_wr && bus_addr == fml_pkg::REG_IRQ_EN, 2))
        else $error("interrupt rose without completion or enable");
endmodule

/* testbench/tb_fml_margin_ctl.sv */
// Self-checking testbench of the margin level command controller.
`timescale 1ns/1ps
module tb_fml_margin_ctl;
    logic        clk_sys          = 1'b0;
    logic        sys_rst          = 1'b1;
    logic [7:0]  bus_addr         = 8'h00;
    logic [15:0] bus_wdata        = 16'h0000;
    logic        bus_wr           = 1'b0;
    logic        bus_rd           = 1'b0;
    logic        special_mode_pin = 1'b0;
    logic [15:0] bus_rdata;
    logic        irq;
    logic [2:0]  pflash_margin;
    logic [2:0]  eeprom_margin;
    logic        busy;
    logic        rd_due           = 1'b0;
    logic [15:0] exp_q[$];
    logic [2:0]  m_pf             = 3'h0;
    logic [2:0]  m_ee             = 3'h0;
    logic [31:0] rng              = 32'h0000331c;
    int          fails            = 0;
    int          n_compared       = 0;

    always #20 clk_sys = ~clk_sys;

    fml_margin_ctl i_dut (
        .clk_sys          (clk_sys),
        .sys_rst          (sys_rst),
        .bus_addr         (bus_addr),
        .bus_wdata        (bus_wdata),
        .bus_wr           (bus_wr),
        .bus_rd           (bus_rd),
        .bus_rdata        (bus_rdata),
        .special_mode_pin (special_mode_pin),
        .irq              (irq),
        .pflash_margin    (pflash_margin),
        .eeprom_margin    (eeprom_margin),
        .busy             (busy)
    );

    // ****************************************************************
    // Bus tasks, checking and the read monitor
    // ****************************************************************
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic chk_irq(input logic e);
        @(negedge clk_sys);
        n_compared++;
        if (irq !== e) begin
            fails++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, irq);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge clk_sys);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd   <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so look mid-cycle.
    always @(posedge clk_sys) rd_due <= bus_rd;
    always @(negedge clk_sys) begin
        if (rd_due === 1'b1 && exp_q.size() > 0) begin
            chk(exp_q.pop_front(), bus_rdata);
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // The expected outcome is reckoned here from the command fields, the launch index and the mode pin alone.
    task automatic cmd(input logic [7:0] code, input logic [23:0] ga,
                       input logic [15:0] set, input logic [2:0] idx,
                       input logic sp);
        logic pf_hit;
        logic ee_hit;
        logic err;
        pf_hit = ga >= fml_pkg::PF_LO_DEF && ga <= fml_pkg::PF_HI_DEF;
        ee_hit = ga >= fml_pkg::EE_LO_DEF && ga <= fml_pkg::EE_HI_DEF;
        err = idx != 3'h2 || !(pf_hit || ee_hit) ||
              !((code == 8'h0d && set <= 16'h0002) ||
                (code == 8'h0e && sp && set <= 16'h0004));
        special_mode_pin <= sp;
        wr(fml_pkg::REG_INDEX, 16'h0000);
        wr(fml_pkg::REG_WORD, {code, ga[23:16]});
        wr(fml_pkg::REG_INDEX, 16'h0001);
        wr(fml_pkg::REG_WORD, ga[15:0]);
        wr(fml_pkg::REG_INDEX, 16'h0002);
        wr(fml_pkg::REG_WORD, set);
        wr(fml_pkg::REG_INDEX, {13'h0000, idx});
        wr(fml_pkg::REG_STATUS, 16'h00a0);
        @(negedge clk_sys);
        for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk_sys);
        chk(16'h0000, {15'h0000, busy});
        if (!err) begin
            m_ee = set[2:0];
            if (pf_hit) m_pf = set[2:0];
        end
        rd(fml_pkg::REG_STATUS,
           err ? 16'h00a0 : 16'h0080);
        rd(fml_pkg::REG_MARGIN, {5'h00, m_ee, 5'h00, m_pf});
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Test sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        tally_and_finish;
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(fml_pkg::REG_STATUS, 16'h0080);
        rd(fml_pkg::REG_MARGIN, 16'h0000);
        rd(fml_pkg::REG_IRQ_EN, 16'h0000);
        rd(8'h0e, 16'h0000);
        $display("test reset done");
        for (int s = 0; s < 3; s++) begin
            cmd(8'h0d, 24'h800000, s[15:0], 3'h2, 1'b0);
            cmd(8'h0d, 24'h1007ff, 16'h0002 - s[15:0], 3'h2, 1'b0);
        end
        $display("test user levels done");
        for (int s = 0; s < 5; s++) begin
            cmd(8'h0e, 24'h100000, s[15:0], 3'h2, 1'b1);
            cmd(8'h0e, 24'hffffff, 16'h0004 - s[15:0], 3'h2, 1'b1);
        end
        $display("test field levels done");
        cmd(8'h0e, 24'h800000, 16'h0003, 3'h2, 1'b0);
        cmd(8'h0d, 24'h800000, 16'h0003, 3'h2, 1'b1);
        cmd(8'h0e, 24'h100000, 16'h0005, 3'h2, 1'b1);
        cmd(8'h0d, 24'h800000, 16'h0001, 3'h1, 1'b0);
        cmd(8'h0e, 24'h800000, 16'h0001, 3'h3, 1'b1);
        cmd(8'h0d, 24'h100800, 16'h0001, 3'h2, 1'b0);
        cmd(8'h0f, 24'h800000, 16'h0001, 3'h2, 1'b1);
        $display("test errors done");
        for (int n = 0; n < 12; n++) begin
            rng = xs(rng);
            cmd(rng[0] ? 8'h0d : 8'h0e,
                rng[2:1] == 2'h0 ? 24'h300000 :
                rng[2] ? {1'b1, rng[30:8]} : {13'h0200, rng[18:8]},
                {13'h0000, rng[7:5]}, rng[4:3] == 2'h0 ? 3'h1 : 3'h2,
                rng[31]);
        end
        $display("test random done");
        wr(fml_pkg::REG_IRQ_CLR, 16'h0003);
        wr(fml_pkg::REG_IRQ_EN, 16'h0001);
        cmd(8'h0d, 24'h800000, 16'h0001, 3'h2, 1'b0);
        chk_irq(1'b1);
        rd(fml_pkg::REG_IRQ_STAT, 16'h0001);
        wr(fml_pkg::REG_IRQ_CLR, 16'h0001);
        chk_irq(1'b0);
        wr(fml_pkg::REG_IRQ_EN, 16'h0002);
        cmd(8'h0d, 24'h800000, 16'h0007, 3'h2, 1'b0);
        chk_irq(1'b1);
        wr(fml_pkg::REG_IRQ_CLR, 16'h0003);
        chk_irq(1'b0);
        $display("test interrupt done");
        cmd(8'h0d, 24'h800000, 16'h0002, 3'h2, 1'b0);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        m_pf = 3'h0;
        m_ee = 3'h0;
        rd(fml_pkg::REG_MARGIN, 16'h0000);
        $display("test second reset done");
        repeat (3) @(posedge clk_sys);
        tally_and_finish;
    end
endmodule

bind fml_margin_ctl fml_margin_checker i_chk (
    .clk_sys          (clk_sys),
    .sys_rst          (sys_rst),
    .bus_addr         (bus_addr),
    .bus_wdata        (bus_wdata),
    .bus_wr           (bus_wr),
    .bus_rd           (bus_rd),
    .bus_rdata        (bus_rdata),
    .special_mode_pin (special_mode_pin),
    .irq              (irq),
    .pflash_margin    (pflash_margin),
    .eeprom_margin    (eeprom_margin),
    .busy             (busy)
);
